// file: hw/fpos_dev.sv
// Flash end: deep sleep, OTP mode and security register command handling
// Operation
// R1 - Sleep entry executes only on byte boundary
// R2 - Stay standby for entry delay, then sleep
// R3 - Sleeping device ignores all instructions
// R4 - Host waits minimum dwell before waking pulse
// R5 - Wake by long select pulse or reset
// R6 - Recovery delay after wake pulse ends
// R7 - OTP enter switches to OTP region
// R8 - Normal commands target OTP while in mode
// R9 - OTP mode rejects register writes; locked: all but reads; the code still takes sleep and OTP exit when locked
// R10 - OTP exit returns to main array
// R11 - Security read accepted anytime, repeatedly
// R12 - Security register shifted out until deselect
// R13 - Bit 0 shows factory lock, read only
// R14 - Bit 1 customer lock, set once
// R15 - Bit 2 program suspended flag
// R16 - Bit 3 erase suspended flag
// R17 - Bit 5 program fail, cleared by success
// R18 - Bit 6 erase fail, cleared by success
// R19 - Host sends write latch before register write; fpos_host sends it only before the security write, not the status write
// R20 - Register write executes only on byte boundary
// R21 - Sleep and wake timings are parameters
`include "fpos_map.svh"
module fpos_dev #(
  parameter int SLEEP_ENTRY_NS = `FPOS_SLEEP_ENTRY_NS,
  parameter int WAKE_PULSE_NS = `FPOS_WAKE_PULSE_NS,
  parameter int WAKE_RECOV_NS = `FPOS_WAKE_RECOV_NS,
  parameter bit FACTORY_LOCKED = 1'b0
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // Link
  fpos_if.dev link,
  // Array engine events, one-cycle pulses
  input wire logic prog_suspend,
  input wire logic prog_resume,
  input wire logic erase_suspend,
  input wire logic erase_resume,
  input wire logic prog_ok,
  input wire logic prog_fail,
  input wire logic erase_ok,
  input wire logic erase_fail,
  // Mode and command outputs
  output logic sleeping,
  output logic otp_mode,
  output logic write_latch,
  output logic cmd_strobe,
  output logic [7:0] cmd_byte,
  output logic cmd_otp,
  output logic status_wr_strobe
);
  localparam logic [15:0] ENTRY_CYC = 16'(fpos_pkg::fpos_cycles(SLEEP_ENTRY_NS)); // R21
  localparam logic [15:0] WAKE_CYC = 16'(fpos_pkg::fpos_cycles(WAKE_PULSE_NS)); // R21
  localparam logic [15:0] RECOV_CYC = 16'(fpos_pkg::fpos_cycles(WAKE_RECOV_NS)); // R21

  logic [2:0] pins_s;
  logic cs_s, sck_s, si_s;

  fpos_sync #(.W(3), .INIT(3'b100)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .d({link.cs_n, link.sck, link.si}),
    .q(pins_s)
  );
  assign cs_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];

  fpos_pkg::fpos_dev_st_t st_q, st_d;
  logic [15:0] tmr_q, tmr_d, low_q, low_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic [7:0] sh_q, sh_d, op_q, op_d, tx_q, tx_d, sec_q, sec_d;
  logic cs_prev_q, sck_prev_q;
  logic so_q, so_d, oe_q, oe_d, wel_q, wel_d, otp_q, otp_d;
  logic cst_q, cst_d, cotp_q, cotp_d, swr_q, swr_d;
  logic [7:0] cb_q, cb_d;

  logic active, sck_rise, sck_fall, cs_rise, reading, single, boundary, read_type;
  logic [7:0] sec_view;

  always_comb begin
    // Listening in standby and during sleep entry; sleep and recovery drop every frame
    active = (st_q == fpos_pkg::DS_STANDBY) || (st_q == fpos_pkg::DS_ENTER); // R3
    sck_rise = sck_s & ~sck_prev_q & ~cs_s;
    sck_fall = ~sck_s & sck_prev_q & ~cs_s;
    cs_rise = cs_s & ~cs_prev_q;
    reading = (op_q == `FPOS_OP_SEC_READ) && (byte_q != 2'd0);
    boundary = (bit_q == 3'd0) && (byte_q != 2'd0);
    single = (bit_q == 3'd0) && (byte_q == 2'd1); // R1 R20
    read_type = (op_q == `FPOS_OP_ARRAY_READ) || (op_q == `FPOS_OP_SEC_READ);
    sec_view = sec_q;
    sec_view[`FPOS_SEC_FACTORY] = FACTORY_LOCKED; // R13

    st_d = st_q;
    tmr_d = tmr_q;
    low_d = low_q;
    bit_d = bit_q;
    byte_d = byte_q;
    sh_d = sh_q;
    op_d = op_q;
    tx_d = tx_q;
    so_d = so_q;
    oe_d = oe_q;
    wel_d = wel_q;
    otp_d = otp_q;
    sec_d = sec_q;
    cst_d = 1'b0;
    cb_d = cb_q;
    cotp_d = cotp_q;
    swr_d = 1'b0;

    if (active && !cs_s) begin
      if (sck_rise) begin
        sh_d = {sh_q[6:0], si_s};
        bit_d = bit_q + 3'd1;
        if (bit_q == 3'd7) begin
          if (byte_q != 2'd3) begin
            byte_d = byte_q + 2'd1;
          end
          if (byte_q == 2'd0) begin
            op_d = {sh_q[6:0], si_s};
          end
        end
      end
      // Reload at each byte start so a repeat read sees live flags
      if (sck_fall && reading) begin // R11
        oe_d = 1'b1;
        if (bit_q == 3'd0) begin
          so_d = sec_view[7]; // R12
          tx_d = {sec_view[6:0], 1'b0};
        end else begin
          so_d = tx_q[7]; // R12
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end

    if (cs_s) begin
      bit_d = 3'd0;
      byte_d = 2'd0;
      op_d = 8'h00;
      oe_d = 1'b0; // R12
    end

    if (cs_rise && active && boundary) begin
      case (op_q)
        `FPOS_OP_SLEEP: begin
          if (single) begin // R1
            st_d = fpos_pkg::DS_ENTER; // R2
            tmr_d = ENTRY_CYC;
          end
        end
        `FPOS_OP_OTP_ENTER: begin
          if (single) begin
            otp_d = 1'b1; // R7
          end
        end
        `FPOS_OP_OTP_EXIT: begin
          if (single) begin
            otp_d = 1'b0; // R10
          end
        end
        `FPOS_OP_WR_LATCH: begin
          if (single && !(otp_q && sec_q[`FPOS_SEC_LOCK])) begin
            wel_d = 1'b1;
          end
        end
        `FPOS_OP_SEC_WRITE: begin
          if (single && wel_q && !otp_q) begin // R9 R20
            sec_d[`FPOS_SEC_LOCK] = 1'b1; // R14
            wel_d = 1'b0;
          end
        end
        `FPOS_OP_STAT_WRITE: begin
          if (!otp_q) begin // R9
            swr_d = 1'b1;
            wel_d = 1'b0;
          end
        end
        `FPOS_OP_SEC_READ: begin
        end
        default: begin
          if (!(otp_q && sec_q[`FPOS_SEC_LOCK] && !read_type)) begin // R9
            cst_d = 1'b1;
            cb_d = op_q;
            cotp_d = otp_q; // R8
          end
        end
      endcase
    end

    case (st_q)
      fpos_pkg::DS_ENTER: begin
        if (tmr_q <= 16'd1) begin
          st_d = fpos_pkg::DS_SLEEP; // R2
          tmr_d = 16'd0;
        end else begin
          tmr_d = tmr_q - 16'd1;
        end
      end
      fpos_pkg::DS_SLEEP: begin
        if (!cs_s && low_q != 16'hffff) begin
          low_d = low_q + 16'd1;
        end
        if (cs_s) begin
          low_d = 16'd0;
        end
        // A short glitch on select must not wake the part
        if (cs_rise && low_q >= WAKE_CYC) begin // R5
          st_d = fpos_pkg::DS_WAKE;
          tmr_d = RECOV_CYC; // R6
        end
      end
      fpos_pkg::DS_WAKE: begin
        low_d = 16'd0;
        if (tmr_q <= 16'd1) begin
          st_d = fpos_pkg::DS_STANDBY; // R6
          tmr_d = 16'd0;
        end else begin
          tmr_d = tmr_q - 16'd1;
        end
      end
      default: begin
        low_d = 16'd0;
      end
    endcase

    // Engine flags: a set beats a clear arriving in the same cycle
    if (prog_suspend) begin
      sec_d[`FPOS_SEC_PSUSP] = 1'b1; // R15
    end else if (prog_resume) begin
      sec_d[`FPOS_SEC_PSUSP] = 1'b0; // R15
    end
    if (erase_suspend) begin
      sec_d[`FPOS_SEC_ESUSP] = 1'b1; // R16
    end else if (erase_resume) begin
      sec_d[`FPOS_SEC_ESUSP] = 1'b0; // R16
    end
    if (prog_fail) begin
      sec_d[`FPOS_SEC_PFAIL] = 1'b1; // R17
    end else if (prog_ok) begin
      sec_d[`FPOS_SEC_PFAIL] = 1'b0; // R17
    end
    if (erase_fail) begin
      sec_d[`FPOS_SEC_EFAIL] = 1'b1; // R18
    end else if (erase_ok) begin
      sec_d[`FPOS_SEC_EFAIL] = 1'b0; // R18
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= fpos_pkg::DS_STANDBY; // R5
      tmr_q <= 16'h0000;
      low_q <= 16'h0000;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      tx_q <= 8'h00;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      wel_q <= 1'b0;
      otp_q <= 1'b0;
      sec_q <= `FPOS_SEC_RESET;
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
      cst_q <= 1'b0;
      cb_q <= 8'h00;
      cotp_q <= 1'b0;
      swr_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      low_q <= low_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      op_q <= op_d;
      tx_q <= tx_d;
      so_q <= so_d;
      oe_q <= oe_d;
      wel_q <= wel_d;
      otp_q <= otp_d;
      sec_q <= sec_d;
      cs_prev_q <= cs_s;
      sck_prev_q <= sck_s;
      cst_q <= cst_d;
      cb_q <= cb_d;
      cotp_q <= cotp_d;
      swr_q <= swr_d;
    end
  end

  assign link.so = so_q;
  assign link.so_oe = oe_q;
  assign sleeping = (st_q == fpos_pkg::DS_SLEEP);
  assign otp_mode = otp_q;
  assign write_latch = wel_q;
  assign cmd_strobe = cst_q;
  assign cmd_byte = cb_q;
  assign cmd_otp = cotp_q;
  assign status_wr_strobe = swr_q;
endmodule

// file: hw/fpos_map.svh
// Offsets, field positions, reset values, opcodes and timing defaults for the sleep/OTP/security block
`ifndef FPOS_MAP_SVH
`define FPOS_MAP_SVH
`define FPOS_SYS_CLK_NS 8
// Instruction codes
`define FPOS_OP_SLEEP 8'h79
`define FPOS_OP_OTP_ENTER 8'hb1
`define FPOS_OP_OTP_EXIT 8'hc1
`define FPOS_OP_SEC_READ 8'h2b
`define FPOS_OP_SEC_WRITE 8'h2c
`define FPOS_OP_WR_LATCH 8'h06
`define FPOS_OP_STAT_WRITE 8'h01
`define FPOS_OP_ARRAY_READ 8'h03
// Security register fields
`define FPOS_SEC_FACTORY 0
`define FPOS_SEC_LOCK 1
`define FPOS_SEC_PSUSP 2
`define FPOS_SEC_ESUSP 3
`define FPOS_SEC_PFAIL 5
`define FPOS_SEC_EFAIL 6
`define FPOS_SEC_RESET 8'h00
// Timing defaults in ns
`define FPOS_SLEEP_ENTRY_NS 3000
`define FPOS_SLEEP_DWELL_NS 30000
`define FPOS_WAKE_PULSE_NS 200
`define FPOS_WAKE_RECOV_NS 30000
// Host serial clock half period in system cycles
`define FPOS_HALF_SCK 3'd4
// Host register offsets and fields
`define FPOS_REG_CMD 8'h00
`define FPOS_REG_STAT 8'h04
`define FPOS_CMD_READ_BIT 8
`define FPOS_CMD_WAKE_BIT 9
`endif

// file: hw/fpos_pkg.sv
// Types and shared helpers of the sleep/OTP/security block
package fpos_pkg;
`include "fpos_map.svh"

  typedef enum logic [1:0] {
    DS_STANDBY = 2'b00,
    DS_ENTER = 2'b01,
    DS_SLEEP = 2'b10,
    DS_WAKE = 2'b11
  } fpos_dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SHIFT = 3'b001,
    HS_TAIL = 3'b010,
    HS_GAP = 3'b011,
    HS_WAKE = 3'b100,
    HS_WAIT = 3'b101
  } fpos_host_st_t;

  // Least time in ns to whole system cycles, never below one
  function automatic int fpos_cycles(input int ns);
    int c;
    c = (ns + `FPOS_SYS_CLK_NS - 1) / `FPOS_SYS_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
endpackage

// file: hw/fpos_if.sv
// Serial link between the host controller and the flash command end
interface fpos_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface

// file: hw/fpos_sync.sv
// Two-flop synchroniser for pins from outside the system clock domain
module fpos_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// file: hw/fpos_host.sv
// Host end: frames single instructions, wake pulses and security reads on the link
`include "fpos_map.svh"
module fpos_host #(
  parameter int SLEEP_ENTRY_NS = `FPOS_SLEEP_ENTRY_NS,
  parameter int SLEEP_DWELL_NS = `FPOS_SLEEP_DWELL_NS,
  parameter int WAKE_PULSE_NS = `FPOS_WAKE_PULSE_NS,
  parameter int WAKE_RECOV_NS = `FPOS_WAKE_RECOV_NS
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Link
  fpos_if.host link
);
  localparam logic [15:0] SLEEP_GUARD_CYC =
    16'(fpos_pkg::fpos_cycles(SLEEP_ENTRY_NS) + fpos_pkg::fpos_cycles(SLEEP_DWELL_NS));
  // Four extra cycles cover the flash end's input synchroniser
  localparam logic [15:0] WAKE_CYC = 16'(fpos_pkg::fpos_cycles(WAKE_PULSE_NS) + 4);
  localparam logic [15:0] RECOV_CYC = 16'(fpos_pkg::fpos_cycles(WAKE_RECOV_NS));

  logic so_s;

  fpos_sync #(.W(1), .INIT(1'b0)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .d(link.so),
    .q(so_s)
  );

  fpos_pkg::fpos_host_st_t st_q, st_d;
  logic [2:0] div_q, div_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] tmr_q, tmr_d, tx_q, tx_d;
  logic [7:0] cur_q, cur_d, rx_q, rx_d, pend_q, pend_d;
  logic pend_rd_q, pend_rd_d, pend_v_q, pend_v_d, rd_mode_q, rd_mode_d;
  logic cs_n_q, cs_n_d, sck_q, sck_d, si_q, si_d;
  logic [31:0] rdata_q, rdata_d;
  logic cmd_wr;

  always_comb begin
    cmd_wr = wr && (addr == `FPOS_REG_CMD) && (st_q == fpos_pkg::HS_IDLE);
    st_d = st_q;
    div_d = div_q;
    cnt_d = cnt_q;
    tmr_d = tmr_q;
    tx_d = tx_q;
    cur_d = cur_q;
    rx_d = rx_q;
    pend_d = pend_q;
    pend_rd_d = pend_rd_q;
    pend_v_d = pend_v_q;
    rd_mode_d = rd_mode_q;
    cs_n_d = cs_n_q;
    sck_d = sck_q;
    si_d = si_q;
    rdata_d = 32'h0000_0000;

    if (rd && addr == `FPOS_REG_STAT) begin
      rdata_d = {16'h0000, rx_q, 7'h00, st_q != fpos_pkg::HS_IDLE};
    end

    case (st_q)
      fpos_pkg::HS_IDLE: begin
        if (cmd_wr && wdata[`FPOS_CMD_WAKE_BIT]) begin
          st_d = fpos_pkg::HS_WAKE; // R5
          cs_n_d = 1'b0;
          tmr_d = WAKE_CYC;
        end else if (cmd_wr) begin
          st_d = fpos_pkg::HS_SHIFT;
          cs_n_d = 1'b0;
          div_d = 3'd0;
          rd_mode_d = wdata[`FPOS_CMD_READ_BIT];
          if (wdata[7:0] == `FPOS_OP_SEC_WRITE) begin
            // Latch-set frame goes out first, the write follows after the gap
            cur_d = `FPOS_OP_WR_LATCH; // R19
            pend_d = wdata[7:0];
            pend_rd_d = wdata[`FPOS_CMD_READ_BIT];
            pend_v_d = 1'b1;
            rd_mode_d = 1'b0;
          end else begin
            cur_d = wdata[7:0];
          end
          tx_d = {cur_d, 8'h00};
          si_d = cur_d[7];
          cnt_d = rd_mode_d ? 5'd16 : 5'd8;
        end
      end
      fpos_pkg::HS_SHIFT: begin
        div_d = div_q + 3'd1;
        if (div_q == `FPOS_HALF_SCK - 3'd1) begin
          div_d = 3'd0;
          if (!sck_q) begin
            sck_d = 1'b1;
          end else begin
            sck_d = 1'b0;
            rx_d = {rx_q[6:0], so_s};
            tx_d = {tx_q[14:0], 1'b0};
            si_d = tx_q[14];
            cnt_d = cnt_q - 5'd1;
            if (cnt_q == 5'd1) begin
              st_d = fpos_pkg::HS_TAIL; // R1 R10
            end
          end
        end
      end
      fpos_pkg::HS_TAIL: begin
        div_d = div_q + 3'd1;
        if (div_q == `FPOS_HALF_SCK - 3'd1) begin
          div_d = 3'd0;
          cs_n_d = 1'b1; // R1 R10
          st_d = fpos_pkg::HS_GAP;
          tmr_d = {12'h000, 1'b0, `FPOS_HALF_SCK} << 1;
        end
      end
      fpos_pkg::HS_GAP: begin
        tmr_d = tmr_q - 16'd1;
        if (tmr_q <= 16'd1) begin
          if (pend_v_q) begin
            pend_v_d = 1'b0;
            cur_d = pend_q;
            rd_mode_d = pend_rd_q;
            tx_d = {pend_q, 8'h00};
            si_d = pend_q[7];
            cnt_d = pend_rd_q ? 5'd16 : 5'd8;
            cs_n_d = 1'b0;
            div_d = 3'd0;
            st_d = fpos_pkg::HS_SHIFT;
          end else if (cur_q == `FPOS_OP_SLEEP) begin
            // No select pulse until the part has settled into sleep
            st_d = fpos_pkg::HS_WAIT; // R4
            tmr_d = SLEEP_GUARD_CYC;
          end else begin
            st_d = fpos_pkg::HS_IDLE;
          end
        end
      end
      fpos_pkg::HS_WAKE: begin
        tmr_d = tmr_q - 16'd1;
        if (tmr_q <= 16'd1) begin
          cs_n_d = 1'b1;
          st_d = fpos_pkg::HS_WAIT; // R6
          tmr_d = RECOV_CYC;
        end
      end
      fpos_pkg::HS_WAIT: begin
        tmr_d = tmr_q - 16'd1;
        if (tmr_q <= 16'd1) begin
          st_d = fpos_pkg::HS_IDLE;
        end
      end
      default: begin
        st_d = fpos_pkg::HS_IDLE;
        cs_n_d = 1'b1;
        sck_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= fpos_pkg::HS_IDLE;
      div_q <= 3'h0;
      cnt_q <= 5'h00;
      tmr_q <= 16'h0000;
      tx_q <= 16'h0000;
      cur_q <= 8'h00;
      rx_q <= 8'h00;
      pend_q <= 8'h00;
      pend_rd_q <= 1'b0;
      pend_v_q <= 1'b0;
      rd_mode_q <= 1'b0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      tx_q <= tx_d;
      cur_q <= cur_d;
      rx_q <= rx_d;
      pend_q <= pend_d;
      pend_rd_q <= pend_rd_d;
      pend_v_q <= pend_v_d;
      rd_mode_q <= rd_mode_d;
      cs_n_q <= cs_n_d;
      sck_q <= sck_d;
      si_q <= si_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.si = si_q;
  assign rdata = rdata_q;
endmodule

// file: tb/fpos_sva.sv
// Concurrent checks on the serial link and the flash end's mode outputs
module fpos_sva_chk #(
  parameter int ENTRY_CYC = 5,
  parameter int WAKE_CYC = 5
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_oe,
  // Flash end
  input wire logic sleeping,
  input wire logic otp_mode,
  input wire logic write_latch,
  input wire logic cmd_strobe,
  input wire logic status_wr_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] hi_q, hi_d, lo_q, lo_d, last_q, last_d;

  // Saturating counts of select high and low, and the length of the last low pulse
  always_comb begin
    hi_d = cs_n ? ((hi_q == 8'hff) ? hi_q : hi_q + 8'h01) : 8'h00;
    lo_d = !cs_n ? ((lo_q == 8'hff) ? lo_q : lo_q + 8'h01) : 8'h00;
    last_d = (cs_n && lo_q != 8'h00) ? lo_q : last_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      last_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      last_q <= last_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck) else $error("serial clock not idle low");
  a_si_steady_high: assert property (sck && $past(sck) |-> $stable(si)) else $error("data moved while clock high");
  a_so_release: assert property (cs_n [*6] |-> !so_oe) else $error("output still driven after deselect");
  a_so_in_frame: assert property ($rose(so_oe) |-> !cs_n) else $error("output driven outside a frame");
  a_cmd_after_frame: assert property (cmd_strobe |-> cs_n ##1 !cmd_strobe) else $error("command strobe misplaced");
  a_sleep_entry_wait: assert property ($rose(sleeping) |-> hi_q >= ENTRY_CYC) else $error("sleep entered too early");
  a_sleep_silent: assert property (sleeping |-> !so_oe && !cmd_strobe && !status_wr_strobe && $stable(otp_mode))
    else $error("sleeping end acted on a frame");
  a_wake_pulse_len: assert property ($fell(sleeping) |-> last_q >= WAKE_CYC) else $error("woke on a short pulse");
  a_wake_recovery: assert property ($fell(sleeping) |-> !(cmd_strobe || so_oe || status_wr_strobe) [*8])
    else $error("frame served during recovery");
  a_otp_no_status: assert property (otp_mode |-> !status_wr_strobe) else $error("status write taken in otp mode");
  a_latch_frame_end: assert property ($changed(write_latch) |-> cs_n) else $error("latch moved inside a frame");
  a_otp_frame_end: assert property ($changed(otp_mode) |-> cs_n && !sleeping) else $error("otp mode moved badly");
endmodule

// file: tb/test_flash_powerdown_otp_security.sv
// Testbench: host and flash ends joined by a link, plus a bench-driven second link
`include "fpos_map.svh"
module test_flash_powerdown_otp_security;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [9:0] cmd; logic [7:0] ev; logic otp; logic latch; logic [1:0] nst; logic [7:0] rx;} fpos_row_t;
  // Short timings keep the run brief: entry, dwell, pulse and recovery in ns
  localparam int EN = 40;
  localparam int DW = 80;
  localparam int WP = 40;
  localparam int RC = 80;
  logic sys_clk = 1'b0, reset = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, ev = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic sleeping, otp_mode, write_latch, cmd_strobe, cmd_otp, status_wr_strobe, sl_b, wl_b, so_b_w, sck_p, oe_b_seen;
  logic [7:0] cmd_byte, sh;
  logic [8:0] last;
  logic [1:0] nst = 2'd0;
  logic [23:0] r;
  int fails = 0, tests_run = 0;
  fpos_row_t rows [0:18] = '{
    '{10'h12b, 8'h01, 1'b0, 1'b0, 2'd0, 8'h04}, '{10'h12b, 8'h06, 1'b0, 1'b0, 2'd0, 8'h08},
    '{10'h12b, 8'ha8, 1'b0, 1'b0, 2'd0, 8'h60}, '{10'h12b, 8'h50, 1'b0, 1'b0, 2'd0, 8'h00},
    '{10'h12b, 8'h30, 1'b0, 1'b0, 2'd0, 8'h20}, '{10'h006, 8'h00, 1'b0, 1'b1, 2'd0, 8'h00},
    '{10'h0b1, 8'h00, 1'b1, 1'b1, 2'd0, 8'h00}, '{10'h001, 8'h00, 1'b1, 1'b1, 2'd0, 8'h00},
    '{10'h02c, 8'h00, 1'b1, 1'b1, 2'd0, 8'h00}, '{10'h12b, 8'h00, 1'b1, 1'b1, 2'd0, 8'h20},
    '{10'h003, 8'h00, 1'b1, 1'b1, 2'd0, 8'h00}, '{10'h0c1, 8'h00, 1'b0, 1'b1, 2'd0, 8'h00},
    '{10'h003, 8'h00, 1'b0, 1'b1, 2'd0, 8'h00}, '{10'h001, 8'h00, 1'b0, 1'b0, 2'd1, 8'h00},
    '{10'h02c, 8'h00, 1'b0, 1'b0, 2'd1, 8'h00}, '{10'h12b, 8'h00, 1'b0, 1'b0, 2'd1, 8'h22},
    '{10'h0b1, 8'h00, 1'b1, 1'b0, 2'd1, 8'h00}, '{10'h006, 8'h00, 1'b1, 1'b0, 2'd1, 8'h00},
    '{10'h12b, 8'h00, 1'b1, 1'b0, 2'd1, 8'h22}};

  fpos_if link_a();
  fpos_if link_b();
  initial begin
    link_b.cs_n = 1'b1;
    link_b.sck = 1'b0;
    link_b.si = 1'b0;
  end
  // Nobody drives the second link's data line while the flash end lets go
  assign so_b_w = link_b.so_oe ? link_b.so : 1'bz;

  always #4 sys_clk = ~sys_clk;

  fpos_host #(.SLEEP_ENTRY_NS(EN), .SLEEP_DWELL_NS(DW), .WAKE_PULSE_NS(WP), .WAKE_RECOV_NS(RC)) fpos_host_inst (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link(link_a.host));
  fpos_dev #(.SLEEP_ENTRY_NS(EN), .WAKE_PULSE_NS(WP), .WAKE_RECOV_NS(RC), .FACTORY_LOCKED(1'b0)) fpos_dev_inst (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .link(link_a.dev), .prog_suspend(ev[0]), .prog_resume(ev[1]),
    .erase_suspend(ev[2]), .erase_resume(ev[3]), .prog_ok(ev[4]), .prog_fail(ev[5]), .erase_ok(ev[6]),
    .erase_fail(ev[7]), .sleeping(sleeping), .otp_mode(otp_mode), .write_latch(write_latch),
    .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte), .cmd_otp(cmd_otp), .status_wr_strobe(status_wr_strobe));
  fpos_dev #(.SLEEP_ENTRY_NS(EN), .WAKE_PULSE_NS(WP), .WAKE_RECOV_NS(RC), .FACTORY_LOCKED(1'b1)) fpos_dev_inst_b (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .link(link_b.dev), .prog_suspend(ev[0]), .prog_resume(ev[1]),
    .erase_suspend(ev[2]), .erase_resume(ev[3]), .prog_ok(ev[4]), .prog_fail(ev[5]), .erase_ok(ev[6]),
    .erase_fail(ev[7]), .sleeping(sl_b), .otp_mode(), .write_latch(wl_b), .cmd_strobe(), .cmd_byte(),
    .cmd_otp(), .status_wr_strobe());
  fpos_sva_chk #(.ENTRY_CYC(EN / 8), .WAKE_CYC(WP / 8)) fpos_sva_chk_inst (
    .sys_clk(sys_clk), .reset(reset), .cs_n(link_a.cs_n), .sck(link_a.sck), .si(link_a.si), .so_oe(link_a.so_oe),
    .sleeping(sleeping), .otp_mode(otp_mode), .write_latch(write_latch), .cmd_strobe(cmd_strobe),
    .status_wr_strobe(status_wr_strobe));

  // Observers: last command, status write count, bits seen on the first link, drive on the second
  always @(posedge sys_clk) begin
    if (cmd_strobe) last <= {cmd_otp, cmd_byte};
    if (status_wr_strobe) nst <= nst + 2'd1;
    sck_p <= link_a.sck;
    if (link_a.sck && !sck_p) sh <= {sh[6:0], link_a.si};
    if (link_b.so_oe) oe_b_seen <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // One host command, then poll until the host is idle again
  task automatic host_do(input logic [31:0] c, output logic [31:0] v);
    bus_wr(`FPOS_REG_CMD, c);
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 400; k++) begin
      bus_rd(`FPOS_REG_STAT, v);
      if (v[0] === 1'b0) break;
    end
    chk(v[0], 32'h0);
  endtask

  task automatic pulse(input logic [7:0] e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 8'h00;
  endtask

  // Bench-driven frame of n bits, MSB first, sampling the reply before each falling clock
  task automatic bang(input logic [23:0] v, input int n, output logic [23:0] rx);
    rx = '0;
    @(posedge sys_clk);
    link_b.cs_n <= 1'b0;
    link_b.si <= v[n-1];
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      link_b.sck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rx = {rx[22:0], so_b_w};
      link_b.sck <= 1'b0;
      if (i > 0) link_b.si <= v[i-1];
    end
    repeat (4) @(posedge sys_clk);
    link_b.cs_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bang(24'h00002c, 8, r);
    bang(24'h2b0000, 24, r);
    chk(r[15:0], 16'h0101);
    bang(24'h000006, 8, r);
    bang(24'h000058, 9, r);
    chk(wl_b, 1'b1);
    bang(24'h00002c, 8, r);
    chk(wl_b, 1'b0);
    bang(24'h2b0000, 24, r);
    chk(r[15:0], 16'h0303);
    bang(24'h0000f2, 9, r);
    repeat (20) @(posedge sys_clk);
    chk(sl_b, 1'b0);
    bang(24'h000079, 8, r);
    repeat (10) @(posedge sys_clk);
    chk(sl_b, 1'b1);
    oe_b_seen <= 1'b0;
    bang(24'h2b0000, 24, r);
    chk(oe_b_seen, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(sl_b, 1'b0);
    for (int i = 0; i < 19; i++) begin
      pulse(rows[i].ev);
      host_do({22'h0, rows[i].cmd}, d);
      chk(otp_mode, rows[i].otp);
      chk(write_latch, rows[i].latch);
      chk(nst, rows[i].nst);
      if (rows[i].cmd[8]) chk(d[15:8], rows[i].rx);
      else chk(sh, rows[i].cmd[7:0]);
      if (rows[i].cmd[7:0] == 8'h03) chk(last, {rows[i].otp, 8'h03});
    end
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({otp_mode, write_latch}, 2'b00);
    host_do(32'h79, d);
    chk(sleeping, 1'b1);
    host_do(32'hb1, d);
    chk(otp_mode, 1'b0);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(sleeping, 1'b0);
    host_do(32'h12b, d);
    chk(d[15:8], 8'h00);
    host_do(32'h79, d);
    host_do(32'h200, d);
    chk(sleeping, 1'b0);
    host_do(32'hb1, d);
    chk(otp_mode, 1'b1);
    complete_run();
  end

  // The whole sequence needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
endmodule
